// ### core/dlcop_defs.svh
// Constants of the display list coprocessor: offsets, fields, resets
// What this block does
// - Fetch instructions only from chip memory.
// - While waiting, watch beam, request no bus.
// - After a wait, claim cycles for transfer.
// - Request the memory bus in odd cycles only.
// - Decode exactly wait, move and skip.
// - Each instruction is two fetched 16-bit words.
// - Skip bypasses next instruction once beam reached.
// - Move and skip take two memory cycles.
// - Wait takes three memory cycles, one waking.
// - Move word one: bit0 zero, bits8-1 destination.
// - Move writes second word unchanged as data.
// - Hex 10 to 20 needs danger bit set.
// - Never write registers below hex 10.
// - Wait word one: bit0 one, vertical, horizontal.
// - Wait word two: blitter bit, compare enables.
// - Wait ends when masked beam reaches target.
`ifndef DLCOP_DEFS_SVH
`define DLCOP_DEFS_SVH

// Register word indices on the bus (byte address is four times)
`define DLCOP_IDX_CTRL       2'h0
`define DLCOP_IDX_LIST       2'h1
`define DLCOP_IDX_STAT       2'h2

// Control register fields and reset value
`define DLCOP_CTRL_RUN       0
`define DLCOP_CTRL_DANGER    1
`define DLCOP_CTRL_RST       2'h0

// Instruction word fields
`define DLCOP_W_KIND         0
`define DLCOP_DA_HI          8
`define DLCOP_DA_LO          1
`define DLCOP_VP_HI          15
`define DLCOP_VP_LO          8
`define DLCOP_HP_HI          7
`define DLCOP_HP_LO          1
`define DLCOP_BFD            15
`define DLCOP_VE_HI          14
`define DLCOP_VE_LO          8
`define DLCOP_HE_HI          7
`define DLCOP_HE_LO          1

// Protection floors on destination register addresses
`define DLCOP_FLOOR_ALWAYS   9'h020
`define DLCOP_FLOOR_DANGER   9'h010

`endif

// ### core/dlcop_pkg.sv
// Types shared by the display list coprocessor
package dlcop_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    DLCOP_IDLE,
    DLCOP_FETCH1,
    DLCOP_FETCH2,
    DLCOP_EXEC,
    DLCOP_WAIT,
    DLCOP_WAKE
  } dlcop_state_type;

endpackage

// ### core/dlcop_beam_cmp.sv
// Masked beam position comparator for wait and skip
`timescale 1ns/10ps
`include "dlcop_defs.svh"

module dlcop_beam_cmp
  import dlcop_pkg::*;
(
  input  wire logic [15:0] first_word,   // Target positions
  input  wire logic [15:0] second_word,  // Compare enables
  input  wire logic [7:0]  beam_v,       // Vertical beam counter
  input  wire logic [7:1]  beam_h,       // Horizontal beam counter
  output logic             reached       // Beam at or past target
);

  // Vertical top bit is always compared; only bits 6..0 are maskable
  logic [7:0]  vmask;
  logic [6:0]  hmask;
  logic [14:0] pos_masked;
  logic [14:0] tgt_masked;
  logic [14:0] pos_raw;
  logic [14:0] tgt_raw;
  logic [14:0] mask_all;

  assign vmask    = {1'b1, second_word[`DLCOP_VE_HI:`DLCOP_VE_LO]};
  assign hmask    = second_word[`DLCOP_HE_HI:`DLCOP_HE_LO];
  assign mask_all = {vmask, hmask};
  assign pos_raw  = {beam_v, beam_h};
  // Target fields sit in the first word
  assign tgt_raw  = {first_word[`DLCOP_VP_HI:`DLCOP_VP_LO],
                     first_word[`DLCOP_HP_HI:`DLCOP_HP_LO]};

  // Per-bit masking of both sides
  genvar gi;
  generate
    for (gi = 0; gi < 15; gi = gi + 1) begin : g_mask
      assign pos_masked[gi] = pos_raw[gi] & mask_all[gi];
      assign tgt_masked[gi] = tgt_raw[gi] & mask_all[gi];
    end
  endgenerate

  // Equal or greater ends the wait or takes the skip
  assign reached = (pos_masked >= tgt_masked);

endmodule

// ### core/dlcop_top.sv
// Display list coprocessor: fetch, decode, wait, move, skip, bus slave
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/10ps
`include "dlcop_defs.svh"

module dlcop_top
  import dlcop_pkg::*;
#(
  parameter int CHIP_AW = 19               // Chip memory word address bits
)
(
  input  wire logic               clk_sys,       // 50 MHz system clock
  input  wire logic               resetn,        // Async reset, low
  // Classic Wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [3:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // Chip memory DMA read port
  input  wire logic               mem_odd_cycle, // Current slot is odd
  output logic                    mem_req,       // Request this slot
  output logic      [CHIP_AW-1:0] mem_addr,      // Word address
  input  wire logic               mem_gnt,       // Slot granted, data valid
  input  wire logic [15:0]        mem_rdata,     // Read word
  // Chip register write port
  output logic                    reg_we,        // One-cycle write strobe
  output logic      [8:0]         reg_addr,      // Byte address, bit0 zero
  output logic      [15:0]        reg_wdata,     // Data to write
  // Beam and blitter status
  input  wire logic [7:0]         beam_v,        // Vertical beam counter
  input  wire logic [7:1]         beam_h,        // Horizontal beam counter
  input  wire logic               blit_busy,     // Blitter still running
  input  wire logic               list_restart   // Reload list start
);

  // Reset release through two flops
  logic rst_meta_reg;
  logic rst_n_reg;

  // Reset synchroniser; assert asynchronously, release on the clock
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // Software-visible state
  logic [1:0]         ctrl_reg;     // Run and danger bits
  logic [1:0]         ctrl_next;
  logic [CHIP_AW-1:0] list_reg;     // List start word address
  logic [CHIP_AW-1:0] list_next;
  logic               ack_reg;
  logic [31:0]        rdat_reg;

  // Bus decode wires
  logic        bus_req;
  logic        bus_wr;
  logic [1:0]  bus_idx;
  logic        hit_ctrl;
  logic        hit_list;
  logic        hit_stat;
  logic [31:0] wmask;
  logic [31:0] ctrl_wide;
  logic [31:0] list_wide;
  logic [31:0] stat_wide;
  logic [31:0] rd_mux;
  logic [31:0] ctrl_merge;
  logic [31:0] list_merge;

  assign bus_req  = wb_cyc_i & wb_stb_i;
  // Write commits at the edge where the master sees ack high
  assign bus_wr   = bus_req & wb_we_i & ack_reg;
  assign bus_idx  = wb_adr_i[3:2];
  assign hit_ctrl = (bus_idx == `DLCOP_IDX_CTRL);
  assign hit_list = (bus_idx == `DLCOP_IDX_LIST);
  assign hit_stat = (bus_idx == `DLCOP_IDX_STAT);

  // Byte enables expand to a bit mask
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb = gb + 1) begin : g_sel
      assign wmask[gb*8 +: 8] = {8{wb_sel_i[gb]}};
    end
  endgenerate

  // Sequencer state
  dlcop_state_type    state_reg;
  dlcop_state_type    state_next;
  logic [CHIP_AW-1:0] pc_reg;       // Next fetch word address
  logic [CHIP_AW-1:0] pc_next;
  logic [15:0]        word1_reg;    // First instruction word
  logic [15:0]        word1_next;
  logic [15:0]        word2_reg;    // Second instruction word
  logic [15:0]        word2_next;
  logic               run_q_reg;    // Run bit delayed, edge detect
  logic               we_reg;
  logic               we_next;
  logic [8:0]         waddr_reg;
  logic [8:0]         waddr_next;
  logic [15:0]        wdata_reg;
  logic [15:0]        wdata_next;

  // Register views
  assign ctrl_wide  = {30'h0, ctrl_reg};
  assign list_wide  = {{(32-CHIP_AW){1'b0}}, list_reg};
  assign stat_wide  = {{(29-CHIP_AW){1'b0}}, pc_reg, state_reg};
  assign rd_mux     = hit_ctrl ? ctrl_wide :
                      hit_list ? list_wide :
                      hit_stat ? stat_wide : 32'h0;
  assign ctrl_merge = (ctrl_wide & ~wmask) | (wb_dat_i & wmask);
  assign list_merge = (list_wide & ~wmask) | (wb_dat_i & wmask);
  assign ctrl_next  = (bus_wr && hit_ctrl) ? ctrl_merge[1:0] : ctrl_reg;
  assign list_next  = (bus_wr && hit_list) ? list_merge[CHIP_AW-1:0]
                                           : list_reg;

  // Bus answer: ack one cycle after the request, dropped the next
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      ack_reg  <= bus_req & ~ack_reg;
      rdat_reg <= rd_mux;
    end
  end

  // Control and list start registers; status is read only
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ctrl_reg <= `DLCOP_CTRL_RST;
      list_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      list_reg <= list_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // Decode of the held instruction
  logic       run_bit;
  logic       danger_bit;
  logic       run_start;
  logic       is_move;
  logic       is_wait;
  logic       is_skip;
  logic       reached;
  logic       blit_ok;
  logic [8:0] dest_addr;
  logic       dest_ok;
  logic       fetch_st;
  logic       grant;

  assign run_bit    = ctrl_reg[`DLCOP_CTRL_RUN];
  assign danger_bit = ctrl_reg[`DLCOP_CTRL_DANGER];
  assign run_start  = run_bit & ~run_q_reg;
  // Kind is told by bit0 of both words
  assign is_move    = ~word1_reg[`DLCOP_W_KIND];
  assign is_wait    = word1_reg[`DLCOP_W_KIND] &
                      ~word2_reg[`DLCOP_W_KIND];
  assign is_skip    = word1_reg[`DLCOP_W_KIND] &
                      word2_reg[`DLCOP_W_KIND];
  // Clear blitter-finished-disable also waits for the blitter
  assign blit_ok    = word2_reg[`DLCOP_BFD] | ~blit_busy;
  assign dest_addr  = {word1_reg[`DLCOP_DA_HI:`DLCOP_DA_LO], 1'b0};
  // Protection floor, relaxed by the danger bit
  assign dest_ok    = (dest_addr >= `DLCOP_FLOOR_ALWAYS) ||
                      (danger_bit &&
                       dest_addr >= `DLCOP_FLOOR_DANGER);
  // Fetch or wake slots claim the bus, odd slots only
  assign fetch_st   = (state_reg == DLCOP_FETCH1) ||
                      (state_reg == DLCOP_FETCH2) ||
                      (state_reg == DLCOP_WAKE);
  assign mem_req    = fetch_st & mem_odd_cycle & run_bit;
  assign grant      = mem_req & mem_gnt;
  // Address is always a chip memory word address
  assign mem_addr   = pc_reg;

  dlcop_beam_cmp u_cmp (
    .first_word  (word1_reg),
    .second_word (word2_reg),
    .beam_v      (beam_v),
    .beam_h      (beam_h),
    .reached     (reached)
  );

  // Next-state logic of the sequencer
  always_comb begin
    state_next = state_reg;
    pc_next    = pc_reg;
    word1_next = word1_reg;
    word2_next = word2_reg;
    we_next    = 1'b0;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    case (state_reg)
      DLCOP_IDLE: begin
        // Start only on a rising run bit
        if (run_start) begin
          pc_next    = list_reg;
          state_next = DLCOP_FETCH1;
        end
      end
      DLCOP_FETCH1: begin
        if (grant) begin
          word1_next = mem_rdata;
          pc_next    = pc_reg + 1'b1;
          state_next = DLCOP_FETCH2;
        end
      end
      DLCOP_FETCH2: begin
        if (grant) begin
          word2_next = mem_rdata;
          pc_next    = pc_reg + 1'b1;
          state_next = DLCOP_EXEC;
        end
      end
      DLCOP_EXEC: begin
        state_next = DLCOP_FETCH1;
        if (is_move) begin
          // Blocked moves are silently dropped
          we_next    = dest_ok;
          waddr_next = dest_addr;
          wdata_next = word2_reg;
        end else if (is_skip) begin
          if (reached) begin
            pc_next = pc_reg + 2'h2;
          end
        end else if (is_wait) begin
          state_next = DLCOP_WAIT;
        end
      end
      DLCOP_WAIT: begin
        // Beam watched directly, no bus traffic
        if (reached && blit_ok) begin
          state_next = DLCOP_WAKE;
        end
      end
      DLCOP_WAKE: begin
        // One extra memory cycle to wake up
        if (grant) begin
          state_next = DLCOP_FETCH1;
        end
      end
      default: begin
        state_next = DLCOP_IDLE;
      end
    endcase
    // Restart reloads the list; clearing run halts at once
    if (!run_bit) begin
      state_next = DLCOP_IDLE;
      we_next    = 1'b0;
    end else if (list_restart) begin
      pc_next    = list_reg;
      state_next = DLCOP_FETCH1;
      we_next    = 1'b0;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= DLCOP_IDLE;
      pc_reg    <= '0;
      word1_reg <= 16'h0;
      word2_reg <= 16'h0;
      run_q_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pc_reg    <= pc_next;
      word1_reg <= word1_next;
      word2_reg <= word2_next;
      run_q_reg <= run_bit;
    end
  end

  // Register write port flops
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      we_reg    <= 1'b0;
      waddr_reg <= 9'h0;
      wdata_reg <= 16'h0;
    end else begin
      we_reg    <= we_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
    end
  end

  assign reg_we    = we_reg;
  assign reg_addr  = waddr_reg;
  assign reg_wdata = wdata_reg;

  // Checks on the sequencer and ports
  a_odd_slot_only: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    mem_req |-> mem_odd_cycle)
    else $error("bus requested in an even slot");

  a_wait_off_bus: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    (state_reg == DLCOP_WAIT) |-> !mem_req)
    else $error("bus requested while waiting");

  a_low_reg_never: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    reg_we |-> (reg_addr >= `DLCOP_FLOOR_DANGER))
    else $error("write below the lowest floor");

  a_danger_gate: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    (reg_we && reg_addr < `DLCOP_FLOOR_ALWAYS) |-> $past(danger_bit))
    else $error("protected write without danger bit");

  a_move_data: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    reg_we |-> (reg_wdata == word2_reg &&
                reg_addr == {word1_reg[8:1], 1'b0}))
    else $error("move data or address altered");

  a_two_words: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    (state_reg == DLCOP_FETCH1 && grant && run_bit && !list_restart)
    |=> (state_reg == DLCOP_FETCH2 && pc_reg == $past(pc_reg) + 1'b1))
    else $error("second word not fetched next");

  a_skip_jump: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    (state_reg == DLCOP_EXEC && is_skip && reached && run_bit &&
     !list_restart) |=> (pc_reg == $past(pc_reg) + 2'h2))
    else $error("taken skip did not bypass");

  a_wait_wake: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    (state_reg == DLCOP_WAIT && reached && blit_ok && run_bit &&
     !list_restart) |=> (state_reg == DLCOP_WAKE))
    else $error("satisfied wait did not wake");

  c_move_done: cover property (
    @(posedge clk_sys) disable iff (!rst_n_reg) reg_we);

  c_skip_taken: cover property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    state_reg == DLCOP_EXEC && is_skip && reached);

  c_wait_ended: cover property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    state_reg == DLCOP_WAIT ##1 state_reg == DLCOP_WAKE);

endmodule

// ### testbench/dlcop_mem_model.sv
// Chip memory partner: odd/even slots, same-cycle grant, word store
`timescale 1ns/10ps

module dlcop_mem_model (
  input  wire logic        clk_sys,       // System clock
  input  wire logic        resetn,        // Async reset, low
  input  wire logic        stall,         // Slot held by other DMA
  input  wire logic        ld_we,         // Bench preloads one word
  input  wire logic [5:0]  ld_addr,       // Preload word address
  input  wire logic [15:0] ld_data,       // Preload word
  input  wire logic        mem_req,       // Fetch request
  input  wire logic [18:0] mem_addr,      // Fetch word address
  output logic             mem_odd_cycle, // Current slot is odd
  output logic             mem_gnt,       // Slot granted
  output logic [15:0]      mem_rdata      // Fetched word
);
  logic [15:0] store [64];  // Small chip memory window holding the list
  logic [15:0] last_reg;    // Last word that was driven onto the bus
  wire         take;        // Request meets a free odd slot

  assign take = mem_req && mem_odd_cycle && !stall;
  // Odd slots not held by stall go to us at once, ahead of host and blitter
  assign mem_gnt = take;
  // Idle bus shows the inverse of the last word, so stale data never matches
  assign mem_rdata = take ? store[mem_addr[5:0]] : ~last_reg;

  // Slot parity alternates every cycle; remember the bus history
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mem_odd_cycle <= 1'b0;
      last_reg      <= 16'h0000;
    end else begin
      mem_odd_cycle <= !mem_odd_cycle;
      if (take) begin
        last_reg <= store[mem_addr[5:0]];
      end
    end
  end

  // Bench preload port, not reset so the list can load during reset
  always_ff @(posedge clk_sys) begin
    if (ld_we) begin
      store[ld_addr] <= ld_data;
    end
  end
endmodule

// ### testbench/tb.sv
// Self-checking bench for the display list coprocessor
`timescale 1ns/10ps

module tb;
  logic        clk_sys       = 1'b0;
  logic        resetn        = 1'b0;
  logic        wb_cyc_i      = 1'b0;
  logic        wb_stb_i      = 1'b0;
  logic        wb_we_i       = 1'b0;
  logic [3:0]  wb_adr_i      = 4'h0;
  logic [3:0]  wb_sel_i      = 4'hf;   // Full words unless a lane test
  logic [31:0] wb_dat_i      = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        mem_odd_cycle;
  logic        mem_req;
  logic [18:0] mem_addr;
  logic        mem_gnt;
  logic [15:0] mem_rdata;
  logic        reg_we;
  logic [8:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [7:0]  beam_v        = 8'h10;  // Start above skip, below wait
  logic [7:1]  beam_h        = 7'h00;
  logic        blit_busy     = 1'b0;
  logic        list_restart  = 1'b0;   // One-cycle list reload pulse
  logic        stall         = 1'b0;
  logic        rnd_stall     = 1'b0;   // Enables random slot stealing
  logic        ld_we         = 1'b0;
  logic [5:0]  ld_addr       = 6'h00;
  logic [15:0] ld_data       = 16'h0000;
  logic [5:0]  ld_ptr        = 6'h08;  // List starts at word 8
  logic [15:0] seed          = 16'hf54b;
  logic [31:0] rd;                     // Last bus read data
  logic        in_wait       = 1'b0;   // Counting requests while parked
  logic [24:0] got_q [$];              // Observed {addr, data} writes
  logic [24:0] exp_q [$];              // Expected writes
  logic [8:0]  ma [$];                 // Move destinations in the list
  logic [15:0] md [$];                 // Move data in the list
  bit          ms [$];                 // Move is bypassed by a skip
  int          fails         = 0;
  int          samples_checked = 0;
  int          grants        = 0;
  int          wait_reqs     = 0;

  dlcop_top u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mem_odd_cycle(mem_odd_cycle),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_gnt(mem_gnt),
    .mem_rdata(mem_rdata), .reg_we(reg_we), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .beam_v(beam_v), .beam_h(beam_h),
    .blit_busy(blit_busy), .list_restart(list_restart)
  );

  dlcop_mem_model u_mem (
    .clk_sys(clk_sys), .resetn(resetn), .stall(stall), .ld_we(ld_we),
    .ld_addr(ld_addr), .ld_data(ld_data), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_odd_cycle(mem_odd_cycle),
    .mem_gnt(mem_gnt), .mem_rdata(mem_rdata)
  );

  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;

  // Sixteen-bit LFSR step for repeatable stimulus
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Whether a move to this destination may land
  function automatic bit move_ok(input logic [8:0] a, input logic danger);
    return (a >= 9'h020) || (danger && a >= 9'h010);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Random horizontal beam, blitter and slot stealing; unused fields must not matter
  always @(posedge clk_sys) begin
    seed      <= lfsr(seed);
    beam_h    <= seed[7:1];
    blit_busy <= seed[0];
    stall     <= rnd_stall & seed[3];
  end

  // Watch the fetch and write ports every cycle
  always @(posedge clk_sys) begin
    if (reg_we === 1'b1) got_q.push_back({reg_addr, reg_wdata});
    if (mem_req === 1'b1 && mem_gnt === 1'b1) grants++;
    if (in_wait && mem_req === 1'b1) wait_reqs++;
    if (mem_req === 1'b1) check(mem_odd_cycle, 1'b1, "even slot");
  end

  // One classic Wishbone cycle; held until ack, the watchdog bounds it
  task automatic wb_xfer(input logic we, input logic [3:0] a,
                         input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic put_word(input logic [15:0] w);
    @(posedge clk_sys);
    ld_we   <= 1'b1;
    ld_addr <= ld_ptr;
    ld_data <= w;
    ld_ptr = ld_ptr + 6'h01;
  endtask

  // Move with random data; first word carries the destination
  task automatic mv(input logic [8:0] a, input bit skipped);
    logic [15:0] d;
    d = seed;
    put_word({7'h00, a[8:1], 1'b0});
    put_word(d);
    ma.push_back(a);
    md.push_back(d);
    ms.push_back(skipped);
  endtask

  // Start the list and compare writes and slot use
  task automatic run_pass(input logic danger, input bit hold,
                          input bit restart, input string name);
    int n;
    got_q.delete();
    exp_q.delete();
    foreach (ma[i]) if (!ms[i] && move_ok(ma[i], danger))
      exp_q.push_back({ma[i], md[i]});
    if (restart) begin
      // Reload pulse while parked; run stays set
      @(posedge clk_sys);
      grants = 0;
      list_restart <= 1'b1;
      @(posedge clk_sys);
      list_restart <= 1'b0;
    end else begin
      wb_xfer(1'b1, 4'h0, 32'h0);
      grants = 0;
      wb_xfer(1'b1, 4'h0, {30'h0, danger, 1'b1});
    end
    if (hold) begin
      n = 0;
      do begin
        wb_xfer(1'b0, 4'h8, 32'h0);
        n++;
      end while (rd[2:0] !== 3'h4 && n < 100);
      check(rd[2:0], 3'h4, "not parked in wait");
      in_wait = 1'b1;
      repeat (40) @(posedge clk_sys);
      in_wait = 1'b0;
      check(wait_reqs, 0, "request while waiting");
      check(got_q.size(), 2, "writes before wait");
      beam_v <= 8'h50;
    end
    n = 0;
    do begin
      wb_xfer(1'b0, 4'h8, 32'h0);
      n++;
    end while ((got_q.size() < exp_q.size() || rd[2:0] !== 3'h4) && n < 400);
    check(rd[2:0], 3'h4, "list not parked");
    check(grants, 19, "slot count");
    check(got_q.size(), exp_q.size(), "write count");
    foreach (exp_q[i]) if (i < got_q.size())
      check(got_q[i], exp_q[i], "write content");
    $display("done %s", name);
  endtask

  // Watchdog: far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    wrap_up();
  end

  // Main sequence; reset first, the list loads while the core is idle
  initial begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    mv(9'h008, 1'b0);
    mv(9'h018, 1'b0);
    mv(9'h020, 1'b0);
    put_word(16'h0801);  // Skip, beam already past line 8
    put_word(16'hff01);
    mv(9'h022, 1'b1);
    put_word(16'h8001);  // Skip not taken, line 128 not reached
    put_word(16'hff01);
    mv(9'h1fe, 1'b0);
    put_word(16'h4001);  // Wait for line 64 and an idle blitter
    put_word(16'h7f00);
    mv(9'h040, 1'b0);
    put_word(16'hffff);  // Never reached, parks the list
    put_word(16'hfffe);
    @(posedge clk_sys);
    ld_we <= 1'b0;
    wb_xfer(1'b0, 4'h0, 32'h0);
    check(rd, 32'h0, "control reset");
    wb_xfer(1'b1, 4'hc, 32'hffffffff);
    wb_xfer(1'b0, 4'hc, 32'h0);
    check(rd, 32'h0, "unmapped read");
    wb_xfer(1'b1, 4'h4, 32'h8);
    wb_xfer(1'b0, 4'h4, 32'h0);
    check(rd, 32'h8, "list start readback");
    // Only byte lane 1 may change
    wb_sel_i <= 4'h2;
    wb_xfer(1'b1, 4'h4, 32'hffffffff);
    wb_sel_i <= 4'hf;
    wb_xfer(1'b0, 4'h4, 32'h0);
    check(rd, 32'h0000ff08, "byte lane write");
    wb_xfer(1'b1, 4'h4, 32'h8);
    $display("done registers");
    run_pass(1'b0, 1'b1, 1'b0, "protected pass");
    rnd_stall <= 1'b1;
    run_pass(1'b1, 1'b0, 1'b0, "danger pass");
    run_pass(1'b1, 1'b0, 1'b1, "restart pass");
    wrap_up();
  end
endmodule
